// [ltu_pkg.sv]
// Notes on behaviour
// R1 - pattern channels: high, low or ignored
// R2 - function selectable: AND, OR, NAND, NOR
// R3 - fire on becoming satisfied or unsatisfied
// R4 - less-than qualifier: true shorter than limit
// R5 - more-than qualifier: true longer than limit
// R6 - time true interval, fire when it ends
// R7 - never fire when the limit is reached
// R8 - state class: channel four clocks three inputs
// R9 - state clock edge rising or falling
// R10 - per-channel threshold derives each channel level
// R11 - setup/hold defaults: data one, clock two
// R12 - fire on data change inside window
// R13 - software keeps data and clock sources apart
// R14 - one control picks setup/hold clock edge
// R15 - separate clock and data crossing levels
// R16 - one command presets both levels per family
// R17 - clock level crossing is the reference
// R18 - positive setup before, positive hold after
// R19 - setup plus hold kept at least minimum
// R20 - software keeps hold below clock period
// R21 - negative setup or hold shifts window
// R22 - function definitions, unsatisfied option swaps them
// R23 - state: sample at edge, fire if satisfied
// R24 - violation stamped at the exposing clock edge
// R25 - sampled inputs, times counted in clock cycles
// R26 - one-cycle pulse with stamp, then wait release
package ltu_pkg;
  localparam int SMP_W   = 8;
  localparam int NCH     = 4;
  localparam int TW      = 16;
  localparam int LIM_W   = 32;
  localparam int STAMP_W = 32;
  localparam int AW      = 12;

  localparam int CLK_PERIOD_NS = 20;
  localparam int MIN_WIN_NS    = 2;
  localparam int MIN_WIN_CYC_I = (MIN_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic signed [TW:0] MIN_WIN_CYC = (TW+1)'(MIN_WIN_CYC_I < 1 ? 1 : MIN_WIN_CYC_I);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL   = 12'h000;
  localparam logic [AW-1:0] OFS_COND   = 12'h004;
  localparam logic [AW-1:0] OFS_THR    = 12'h008;
  localparam logic [AW-1:0] OFS_LVL    = 12'h00C;
  localparam logic [AW-1:0] OFS_CMD    = 12'h010;
  localparam logic [AW-1:0] OFS_LIMIT  = 12'h014;
  localparam logic [AW-1:0] OFS_SETUP  = 12'h018;
  localparam logic [AW-1:0] OFS_HOLD   = 12'h01C;
  localparam logic [AW-1:0] OFS_STATUS = 12'h020;
  localparam logic [AW-1:0] OFS_STAMP  = 12'h024;

  localparam int CTL_W        = 12;
  localparam int CTL_CLASS    = 0;
  localparam int CTL_FUNC     = 2;
  localparam int CTL_WHEN     = 4;
  localparam int CTL_STEDGE   = 6;
  localparam int CTL_SHEDGE   = 7;
  localparam int CTL_DSRC     = 8;
  localparam int CTL_CSRC     = 10;
  localparam logic [CTL_W-1:0] CTRL_RST = 12'h400;
  localparam int CMD_PRESET_A = 0;
  localparam int CMD_PRESET_B = 1;
  localparam int LVL_DATA     = 8;

  localparam logic [SMP_W-1:0] PRESET_A_LVL = 8'h8C;
  localparam logic [SMP_W-1:0] PRESET_B_LVL = 8'h5D;
  localparam logic [SMP_W-1:0] THR_RST      = 8'h80;
  localparam logic [TW-1:0]    SETUP_RST    = 16'h0001;
  localparam logic [TW-1:0]    HOLD_RST     = 16'h0001;
  localparam logic [LIM_W-1:0] LIMIT_RST    = 32'h0000_0010;

  typedef enum logic [1:0] {
    CLS_PATTERN = 2'b00, CLS_STATE = 2'b01, CLS_SETHOLD = 2'b11, CLS_OFF = 2'b10
  } ltu_class_e;
  typedef enum logic [1:0] {
    FN_AND = 2'b00, FN_OR = 2'b01, FN_NOR = 2'b11, FN_NAND = 2'b10
  } ltu_func_e;
  typedef enum logic [1:0] {
    WH_TRUE = 2'b00, WH_FALSE = 2'b01, WH_LT = 2'b11, WH_GT = 2'b10
  } ltu_when_e;
  typedef enum logic [1:0] {
    CND_X = 2'b00, CND_H = 2'b01, CND_L = 2'b10, CND_X2 = 2'b11
  } ltu_cond_e;
  typedef enum logic {
    DUR_WAIT = 1'b0, DUR_TIME = 1'b1
  } ltu_dur_e;
endpackage : ltu_pkg

// [ltu_top.sv]
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ltu_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [ltu_pkg::AW-1:0]        paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  input  wire logic [ltu_pkg::SMP_W-1:0]     input_channel_one,
  input  wire logic [ltu_pkg::SMP_W-1:0]     input_channel_two,
  input  wire logic [ltu_pkg::SMP_W-1:0]     input_channel_three,
  input  wire logic [ltu_pkg::SMP_W-1:0]     input_channel_four,
  input  wire logic                          holdoff_release,
  output var  logic                          trig_pulse,
  output var  logic [ltu_pkg::STAMP_W-1:0]   trig_stamp,
  output var  logic                          trig_armed
);
  import ltu_pkg::*;
  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [CTL_W-1:0]       ctrl_ff;
  logic [2*NCH-1:0]       cond_ff;
  logic [SMP_W-1:0]       thr_ff [NCH];
  logic [SMP_W-1:0]       clvl_ff;
  logic [SMP_W-1:0]       dlvl_ff;
  logic [LIM_W-1:0]       limit_ff;
  logic signed [TW-1:0]   setup_ff;
  logic signed [TW-1:0]   hold_ff;
  logic [31:0]            prdata_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic [SMP_W-1:0]       smp_meta_ff [NCH];
  logic [SMP_W-1:0]       smp_ff [NCH];
  logic                   rel_meta_ff;
  logic                   rel_ff;
  logic                   armed_ff;
  logic                   trig_ff;
  logic [STAMP_W-1:0]     stamp_ff;
  logic [STAMP_W-1:0]     now_ff;
  logic                   comb_q_ff;
  logic                   ch4_q_ff;
  ltu_dur_e               dur_st_ff;
  logic [LIM_W-1:0]       dur_cnt_ff;
  logic                   d_q_ff;
  logic                   c_q_ff;
  logic [TW-1:0]          since_d_ff;
  logic [TW-1:0]          since_c_ff;
  logic                   c_seen_ff;
  logic [STAMP_W-1:0]     edge_stamp_ff;
  logic [SMP_W-1:0]       smp_in [NCH];
  logic [NCH-1:0]         lvl;
  logic [NCH-1:0]         care;
  logic [NCH-1:0]         hit;
  logic [NCH-1:0]         care_eff;
  logic                   and_v;
  logic                   or_v;
  logic                   comb;
  ltu_class_e             cls;
  ltu_func_e              fn;
  ltu_when_e              wh;
  logic                   qualified;
  logic                   st_edge;
  logic                   d_lvl;
  logic                   c_lvl;
  logic                   d_tr;
  logic                   c_edge;
  logic [TW-1:0]          d_ago;
  logic                   back_hit;
  logic                   fwd_hit;
  logic                   fire;
  logic [STAMP_W-1:0]     fire_stamp;
  logic [31:0]            rdata;
  logic                   addr_hit;
  logic                   wr_en;
  logic signed [TW:0]     wr_val;
  assign cls       = ltu_class_e'(ctrl_ff[CTL_CLASS +: 2]);
  assign fn        = ltu_func_e'(ctrl_ff[CTL_FUNC +: 2]);
  assign wh        = ltu_when_e'(ctrl_ff[CTL_WHEN +: 2]);
  assign qualified = (wh == WH_LT) || (wh == WH_GT);
  assign smp_in[0] = input_channel_one;
  assign smp_in[1] = input_channel_two;
  assign smp_in[2] = input_channel_three;
  assign smp_in[3] = input_channel_four;
  // ----------------------------------------------------------------
  // per-channel sampling, threshold and precondition
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        smp_meta_ff[gi] <= '0;
        smp_ff[gi]      <= '0;
      end else begin
        smp_meta_ff[gi] <= smp_in[gi];
        smp_ff[gi]      <= smp_meta_ff[gi];  // R25
      end
    end
    assign lvl[gi]  = smp_ff[gi] >= thr_ff[gi];  // R10
    assign care[gi] = (cond_ff[2*gi +: 2] == CND_H) || (cond_ff[2*gi +: 2] == CND_L);  // R1
    assign hit[gi]  = (cond_ff[2*gi +: 2] == CND_H) ? lvl[gi] : !lvl[gi];
  end
  // channel four is the clock in state class, never an input
  assign care_eff = (cls == CLS_STATE) ? {1'b0, care[NCH-2:0]} : care;  // R8
  assign and_v    = &(~care_eff | hit);
  assign or_v     = |(care_eff & hit);
  always_comb begin
    case (fn)  // R2 R22
      FN_AND:  comb = and_v;
      FN_NAND: comb = !and_v;
      FN_OR:   comb = or_v;
      default: comb = !or_v;
    endcase
  end

  // ----------------------------------------------------------------
  // apb slave: no wait state, answer in the first access cycle
  // ----------------------------------------------------------------
  assign wr_en  = psel && penable && pwrite && pready_ff;
  assign wr_val = (TW+1)'(signed'(pwdata[TW-1:0]));
  always_comb begin
    addr_hit = 1'b1;
    rdata    = '0;
    if (paddr == OFS_CTRL) begin
      rdata[CTL_W-1:0] = ctrl_ff;
    end else if (paddr == OFS_COND) begin
      rdata[2*NCH-1:0] = cond_ff;
    end else if (paddr == OFS_THR) begin
      rdata = {thr_ff[3], thr_ff[2], thr_ff[1], thr_ff[0]};
    end else if (paddr == OFS_LVL) begin
      rdata[2*SMP_W-1:0] = {dlvl_ff, clvl_ff};
    end else if (paddr == OFS_CMD) begin
      rdata = '0;
    end else if (paddr == OFS_LIMIT) begin
      rdata = limit_ff;
    end else if (paddr == OFS_SETUP) begin
      rdata = 32'(setup_ff);
    end else if (paddr == OFS_HOLD) begin
      rdata = 32'(hold_ff);
    end else if (paddr == OFS_STATUS) begin
      rdata[7:0] = {lvl, 1'b0, dur_st_ff, comb, armed_ff};
    end else if (paddr == OFS_STAMP) begin
      rdata = stamp_ff;
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !addr_hit;
      prdata_ff  <= (psel && !penable && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff  <= CTRL_RST;  // R11
      cond_ff  <= '0;
      limit_ff <= LIMIT_RST;
      for (int i = 0; i < NCH; i++) begin
        thr_ff[i] <= THR_RST;
      end
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) begin
        ctrl_ff <= pwdata[CTL_W-1:0];  // R9 R14
      end else if (paddr == OFS_COND) begin
        cond_ff <= pwdata[2*NCH-1:0];
      end else if (paddr == OFS_THR) begin
        for (int i = 0; i < NCH; i++) begin
          thr_ff[i] <= pwdata[SMP_W*i +: SMP_W];
        end
      end else if (paddr == OFS_LIMIT) begin
        limit_ff <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clvl_ff <= PRESET_A_LVL;
      dlvl_ff <= PRESET_A_LVL;
    end else if (wr_en && paddr == OFS_LVL) begin
      clvl_ff <= pwdata[SMP_W-1:0];  // R15
      dlvl_ff <= pwdata[LVL_DATA +: SMP_W];
    end else if (wr_en && paddr == OFS_CMD && pwdata[CMD_PRESET_A]) begin
      clvl_ff <= PRESET_A_LVL;  // R16
      dlvl_ff <= PRESET_A_LVL;
    end else if (wr_en && paddr == OFS_CMD && pwdata[CMD_PRESET_B]) begin
      clvl_ff <= PRESET_B_LVL;  // R16
      dlvl_ff <= PRESET_B_LVL;
    end
  end
  // writing one time pushes the other so the window never falls below MIN_WIN_CYC
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_ff <= signed'(SETUP_RST);
      hold_ff  <= signed'(HOLD_RST);
    end else if (wr_en && paddr == OFS_SETUP) begin
      setup_ff <= signed'(pwdata[TW-1:0]);  // R21
      if (wr_val + (TW+1)'(hold_ff) < MIN_WIN_CYC) begin
        hold_ff <= TW'(MIN_WIN_CYC - wr_val);  // R19
      end
    end else if (wr_en && paddr == OFS_HOLD) begin
      hold_ff <= signed'(pwdata[TW-1:0]);  // R21
      if (wr_val + (TW+1)'(setup_ff) < MIN_WIN_CYC) begin
        setup_ff <= TW'(MIN_WIN_CYC - wr_val);  // R19
      end
    end
  end

  // ----------------------------------------------------------------
  // pattern duration qualifier
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dur_st_ff  <= DUR_WAIT;
      dur_cnt_ff <= '0;
    end else begin
      case (dur_st_ff)  // R6
        DUR_WAIT: begin
          if (comb) begin
            dur_st_ff  <= DUR_TIME;
            dur_cnt_ff <= LIM_W'(1);
          end
        end
        default: begin
          if (!comb) begin
            dur_st_ff <= DUR_WAIT;
          end else if (dur_cnt_ff != '1) begin
            dur_cnt_ff <= dur_cnt_ff + LIM_W'(1);
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // setup/hold tracking
  // ----------------------------------------------------------------
  assign d_lvl  = smp_ff[ctrl_ff[CTL_DSRC +: 2]] >= dlvl_ff;  // R15
  assign c_lvl  = smp_ff[ctrl_ff[CTL_CSRC +: 2]] >= clvl_ff;
  assign d_tr   = d_lvl ^ d_q_ff;
  assign c_edge = ctrl_ff[CTL_SHEDGE] ? (c_q_ff && !c_lvl) : (!c_q_ff && c_lvl);  // R14 R17
  assign d_ago  = d_tr ? '0 : since_d_ff;
  // change at offset -d_ago must lie in [-setup, hold]
  assign back_hit = (signed'({1'b0, d_ago}) <= (TW+1)'(setup_ff))  // R18 R21
                 && (signed'({1'b0, d_ago}) >= -((TW+1)'(hold_ff)));
  assign fwd_hit  = c_seen_ff && d_tr && !c_edge
                 && (signed'({1'b0, since_c_ff}) <= (TW+1)'(hold_ff))
                 && (signed'({1'b0, since_c_ff}) >= -((TW+1)'(setup_ff)));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_q_ff        <= 1'b0;
      c_q_ff        <= 1'b0;
      since_d_ff    <= '1;
      since_c_ff    <= '1;
      c_seen_ff     <= 1'b0;
      edge_stamp_ff <= '0;
    end else begin
      d_q_ff <= d_lvl;
      c_q_ff <= c_lvl;
      if (d_tr) begin
        since_d_ff <= TW'(1);
      end else if (since_d_ff != '1) begin
        since_d_ff <= since_d_ff + TW'(1);
      end
      if (c_edge) begin
        since_c_ff    <= TW'(1);
        c_seen_ff     <= 1'b1;
        edge_stamp_ff <= now_ff;
      end else if (since_c_ff != '1) begin
        since_c_ff <= since_c_ff + TW'(1);
      end
    end
  end
  // ----------------------------------------------------------------
  // trigger decision
  // ----------------------------------------------------------------
  assign st_edge = ctrl_ff[CTL_STEDGE] ? (ch4_q_ff && !lvl[NCH-1]) : (!ch4_q_ff && lvl[NCH-1]);
  always_comb begin
    fire       = 1'b0;
    fire_stamp = now_ff;
    case (cls)
      CLS_PATTERN: begin
        if (wh == WH_TRUE) begin
          fire = comb && !comb_q_ff;  // R3
        end else if (wh == WH_FALSE) begin
          fire = !comb && comb_q_ff;  // R3 R22
        end else if (dur_st_ff == DUR_TIME && !comb) begin
          // decided only as the true interval ends
          fire = (wh == WH_LT) ? (dur_cnt_ff < limit_ff)  // R4 R7
                               : (dur_cnt_ff > limit_ff);  // R5 R7
        end
      end
      CLS_STATE: begin
        fire = st_edge && ((wh == WH_FALSE) ? !comb : comb);  // R23
      end
      CLS_SETHOLD: begin
        fire       = (c_edge && back_hit) || fwd_hit;  // R12
        fire_stamp = c_edge ? now_ff : edge_stamp_ff;  // R24
      end
      default: fire = 1'b0;
    endcase
    fire = fire && armed_ff;  // R26
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comb_q_ff <= 1'b1;  // reset setup makes comb true: no false edge
      ch4_q_ff  <= 1'b0;
      now_ff    <= '0;
    end else begin
      comb_q_ff <= comb;
      ch4_q_ff  <= lvl[NCH-1];  // R9
      now_ff    <= now_ff + STAMP_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_meta_ff <= 1'b0;
      rel_ff      <= 1'b0;
    end else begin
      rel_meta_ff <= holdoff_release;
      rel_ff      <= rel_meta_ff;
    end
  end
  // release wins over a trigger in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 1'b1;
      trig_ff  <= 1'b0;
      stamp_ff <= '0;
    end else begin
      trig_ff <= fire;  // R26
      if (rel_ff) begin
        armed_ff <= 1'b1;
      end else if (fire) begin
        armed_ff <= 1'b0;
      end
      if (fire) begin
        stamp_ff <= fire_stamp;
      end
    end
  end
  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign trig_pulse = trig_ff;
  assign trig_stamp = stamp_ff;
  assign trig_armed = armed_ff;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_true_ends;
    dur_st_ff == DUR_TIME && !comb;
  endsequence
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready_ff) else $error("no apb answer");
  a_no_fire_disarmed: assert property (@(posedge pclk) disable iff (!presetn)  // R26
    !armed_ff |=> !trig_ff) else $error("trigger while disarmed");
  a_pat_goes_true: assert property (@(posedge pclk) disable iff (!presetn)  // R3
    cls == CLS_PATTERN && wh == WH_TRUE && armed_ff && comb && !comb_q_ff |=> trig_ff)
    else $error("missed goes-true trigger");
  a_pat_goes_false: assert property (@(posedge pclk) disable iff (!presetn)  // R22
    cls == CLS_PATTERN && wh == WH_FALSE && armed_ff && !comb && comb_q_ff |=> trig_ff)
    else $error("missed goes-false trigger");
  a_dur_no_early: assert property (@(posedge pclk) disable iff (!presetn)  // R6
    cls == CLS_PATTERN && qualified && comb ##1 comb |=> !trig_ff)
    else $error("qualified trigger while still true");
  a_dur_gt_fire: assert property (@(posedge pclk) disable iff (!presetn)  // R5
    cls == CLS_PATTERN && wh == WH_GT && armed_ff && dur_cnt_ff > limit_ff
    ##0 s_true_ends |=> trig_ff) else $error("missed more-than trigger");
  a_dur_lt_fire: assert property (@(posedge pclk) disable iff (!presetn)  // R4
    cls == CLS_PATTERN && wh == WH_LT && armed_ff && dur_cnt_ff < limit_ff
    ##0 s_true_ends |=> trig_ff) else $error("missed less-than trigger");
  a_state_edge: assert property (@(posedge pclk) disable iff (!presetn)  // R23
    cls == CLS_STATE && wh == WH_TRUE && armed_ff && st_edge && comb |=> trig_ff)
    else $error("missed state trigger");
  a_sh_stamp: assert property (@(posedge pclk) disable iff (!presetn)  // R24
    cls == CLS_SETHOLD && armed_ff && c_edge && back_hit
    |=> trig_ff && stamp_ff == $past(now_ff)) else $error("bad violation stamp");
  a_min_window: assert property (@(posedge pclk) disable iff (!presetn)  // R19
    (TW+1)'(setup_ff) + (TW+1)'(hold_ff) >= MIN_WIN_CYC) else $error("window below minimum");
endmodule : ltu_top
`default_nettype wire

// [ltu_probe.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// comparator bank of the probed circuit
// ----------------------------------------------------------------
module ltu_probe (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [31:0]               want,
  output var  logic [ltu_pkg::SMP_W-1:0] ch_one,
  output var  logic [ltu_pkg::SMP_W-1:0] ch_two,
  output var  logic [ltu_pkg::SMP_W-1:0] ch_three,
  output var  logic [ltu_pkg::SMP_W-1:0] ch_four
);
  import ltu_pkg::*;
  // codes move only after an edge, so the cycle distances stay exact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ch_four, ch_three, ch_two, ch_one} <= 32'h0;
    end else begin
      {ch_four, ch_three, ch_two, ch_one} <= want;
    end
  end
endmodule : ltu_probe
`default_nettype wire

// [test_logic_trigger_unit.sv]
`timescale 1ns/10ps
`default_nettype none
module test_logic_trigger_unit;
  import ltu_pkg::*;
  typedef struct packed {
    logic [11:0] ctl;
    logic [31:0] b;
    logic [31:0] a;
    logic        e;
  } ltu_row_s;
  // ----------------------------------------------------------------
  // cases: control, codes before, codes after, pulse expected
  // ----------------------------------------------------------------
  localparam ltu_row_s ROWS [16] = '{
    '{12'h400, 32'h5090, 32'h2090, 1'b1}, '{12'h410, 32'h2090, 32'h5090, 1'b1},
    '{12'h404, 32'h5010, 32'h2010, 1'b1}, '{12'h408, 32'h2090, 32'h5090, 1'b1},
    '{12'h40C, 32'h2010, 32'h5010, 1'b1}, '{12'h400, 32'h5010, 32'h2010, 1'b0},
    '{12'h414, 32'h2010, 32'h5010, 1'b1}, '{12'h41C, 32'h5010, 32'h5090, 1'b1},
    '{12'h400, 32'h2090, 32'hFFFF2090, 1'b0}, '{12'h418, 32'h5090, 32'h2090, 1'b1},
    '{12'h401, 32'h2090, 32'hFF002090, 1'b1}, '{12'h441, 32'h2090, 32'hFF002090, 1'b0},
    '{12'h441, 32'hFF002090, 32'h2090, 1'b1}, '{12'h401, 32'h5090, 32'hFF005090, 1'b0},
    '{12'h411, 32'h5090, 32'hFF005090, 1'b1}, '{12'h401, 32'h2010, 32'h2090, 1'b0}};
  localparam logic [43:0] RST [7] = '{{OFS_CTRL, 32'h400}, {OFS_COND, 32'h0},
    {OFS_THR, 32'h80808080}, {OFS_LVL, 32'h8C8C}, {OFS_LIMIT, 32'h10},
    {OFS_SETUP, 32'h1}, {OFS_HOLD, 32'h1}};
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0]        paddr;
  logic [31:0]          pwdata, prdata, lv, rd, s1;
  logic [SMP_W-1:0]     c1, c2, c3, c4;
  logic                 holdoff_release, trig_pulse, trig_armed, er;
  logic [STAMP_W-1:0]   trig_stamp;
  int                   errors = 0;
  int                   checks = 0;
  int                   npulse = 0;
  int                   p0 = 0;

  ltu_probe probe (.pclk(pclk), .presetn(presetn), .want(lv), .ch_one(c1), .ch_two(c2),
    .ch_three(c3), .ch_four(c4));
  ltu_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_channel_one(c1), .input_channel_two(c2),
    .input_channel_three(c3), .input_channel_four(c4), .holdoff_release(holdoff_release),
    .trig_pulse(trig_pulse), .trig_stamp(trig_stamp), .trig_armed(trig_armed));

  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  always @(posedge pclk) if (trig_pulse === 1'b1) npulse <= npulse + 1;

  task automatic summarize();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setw(input logic [31:0] w);
    @(posedge pclk);
    lv <= w;
  endtask : setw

  // settle first so the setup change itself cannot be counted
  task automatic arm();
    repeat (6) @(posedge pclk);
    holdoff_release <= 1'b1;
    repeat (2) @(posedge pclk);
    holdoff_release <= 1'b0;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    p0 = npulse;
  endtask : arm

  task automatic dur(input logic [1:0] wh, input int n, input logic e);
    apb(1'b1, OFS_CTRL, {26'h0, wh, 4'h0} | 32'h400);
    setw(32'h5090);
    arm();
    setw(32'h2090);
    repeat (n - 1) @(posedge pclk);
    setw(32'h5090);
    repeat (2) @(posedge pclk);
    chk("early pulse", 32'h0, 32'(npulse - p0));
    repeat (8) @(posedge pclk);
    chk("timed pulses", {31'h0, e}, 32'(npulse - p0));
  endtask : dur

  // t is the data change in cycles from the clock edge
  task automatic sh(input int t, input logic e);
    setw(32'h0);
    arm();
    if (t < 0) begin
      setw(32'h00FF);
      repeat (-t - 1) @(posedge pclk);
      setw(32'hFFFF);
    end else begin
      setw(t == 0 ? 32'hFFFF : 32'hFF00);
      if (t > 0) begin
        repeat (t - 1) @(posedge pclk);
        setw(32'hFFFF);
      end
    end
    repeat (10) @(posedge pclk);
    chk("window pulses", {31'h0, e}, 32'(npulse - p0));
  endtask : sh

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    summarize();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, holdoff_release} = 4'h0;
    paddr = '0;
    pwdata = '0;
    lv = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("armed after reset", 32'h1, {31'h0, trig_armed});
    chk("stamp after reset", 32'h0, trig_stamp);
    foreach (RST[i]) begin
      apb(1'b0, RST[i][43:32], 32'h0);
      chk("reset register", RST[i][31:0], rd);
    end
    chk("pulses after reset", 32'h0, 32'(npulse));
    apb(1'b0, 12'h028, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, OFS_LVL, 32'h4020);
    apb(1'b0, OFS_LVL, 32'h0);
    chk("separate levels", 32'h4020, rd);
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b0, OFS_LVL, 32'h0);
    chk("preset b", {16'h0, PRESET_B_LVL, PRESET_B_LVL}, rd);
    apb(1'b1, OFS_CMD, 32'h3);
    apb(1'b0, OFS_LVL, 32'h0);
    chk("preset a", {16'h0, PRESET_A_LVL, PRESET_A_LVL}, rd);
    // ch1 high, ch2 low on its own lower threshold, ch3 and ch4 ignored
    apb(1'b1, OFS_COND, 32'hC9);
    apb(1'b1, OFS_THR, 32'h80804080);
    foreach (ROWS[i]) begin
      apb(1'b1, OFS_CTRL, {20'h0, ROWS[i].ctl});
      setw(ROWS[i].b);
      arm();
      setw(ROWS[i].a);
      repeat (10) @(posedge pclk);
      chk("pulses", {31'h0, ROWS[i].e}, 32'(npulse - p0));
    end
    apb(1'b1, OFS_CTRL, 32'h400);
    setw(32'h5090);
    arm();
    setw(32'h2090);
    repeat (10) @(posedge pclk);
    s1 = trig_stamp;
    chk("armed after fire", 32'h0, {31'h0, trig_armed});
    setw(32'h5090);
    setw(32'h2090);
    repeat (10) @(posedge pclk);
    chk("pulses disarmed", 32'h1, 32'(npulse - p0));
    apb(1'b0, OFS_STAMP, 32'h0);
    chk("stamp register", s1, rd);
    chk("stamp set", 32'h1, 32'(s1 !== 32'h0));
    apb(1'b1, OFS_LIMIT, 32'h5);
    dur(WH_LT, 2, 1'b1);
    dur(WH_GT, 2, 1'b0);
    dur(WH_GT, 9, 1'b1);
    dur(WH_LT, 9, 1'b0);
    dur(WH_LT, 5, 1'b0);
    dur(WH_GT, 5, 1'b0);
    // data on ch1, clock on ch2: kept apart
    apb(1'b1, OFS_CTRL, 32'h403);
    apb(1'b1, OFS_SETUP, 32'h2);
    sh(-2, 1'b1);
    sh(-3, 1'b0);
    sh(0, 1'b1);
    sh(1, 1'b1);
    sh(2, 1'b0);
    apb(1'b1, OFS_SETUP, 32'hFFFF);
    apb(1'b0, OFS_SETUP, 32'h0);
    chk("setup signed", 32'hFFFFFFFF, rd);
    apb(1'b0, OFS_HOLD, 32'h0);
    chk("hold adjusted", 32'h2, rd);
    apb(1'b1, OFS_HOLD, 32'h3);
    sh(0, 1'b0);
    sh(2, 1'b1);
    // falling clock edge selected: a rising clock must not count
    apb(1'b1, OFS_CTRL, 32'h483);
    sh(2, 1'b0);
    summarize();
  end
endmodule : test_logic_trigger_unit
`default_nettype wire
